// File: pin_sync.sv
// two-stage synchroniser for the front pins
// assumes asynchronous pin levels and one clock
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // pins and synchronised levels
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } sync_st_t;

    sync_st_t st;
    sync_st_t next_st;

    // ========================================================
    // two flops per bit
    always_comb begin
        next_st.meta = pin_i;
        next_st.held = st.meta;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.held;
endmodule : pin_sync

// File: safe_monitor_model.sv
// monitor emulator: sends decoded code sequences on a fixed period
// assumes the bench holds its commands stable across each clock edge
`timescale 1ns/1ns
module safe_monitor_model #(
    parameter int PERIOD = 40
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // commands from the bench
    input  wire logic       send_i,
    input  wire logic [4:0] addr_i,
    input  wire logic       enable_i,
    input  wire logic       help1_i,
    input  wire logic       help2_i,
    input  wire logic       error_i,
    // decoded sequence towards the block
    output logic            seq_valid_o,
    output logic      [4:0] seq_addr_o,
    output logic            seq_enable_o,
    output logic            seq_help1_o,
    output logic            seq_help2_o,
    output logic            seq_error_o
);
    // ========================================================
    // sequence generator
    int         cnt = 0;
    logic [9:0] cmd;
    logic [8:0] data = 9'h000;
    logic       vld  = 1'b0;

    assign {seq_addr_o, seq_enable_o} = data[8:3];
    assign {seq_help1_o, seq_help2_o, seq_error_o} = data[2:0];
    assign seq_valid_o = vld;

    always @(posedge clk_i) begin
        cmd = {send_i, addr_i, enable_i, help1_i, help2_i, error_i};
        #1;
        cnt = (!resetn_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
        if (resetn_i && cmd[9] && cnt == 0) begin
            // content set by address, circuit state, help and error commands only
            data = cmd[8:0];
            vld = 1'b1;
        end else begin
            // idle lines change every cycle
            data = ~data;
            vld = 1'b0;
        end
    end
endmodule : safe_monitor_model

// File: safe_out_pkg.sv
// constants, field positions and types of the safe output slave control
// assumes a 10 MHz single clock and a bus front end on the same clock
// ============================================================
// Overview of operation
// - answer on a safety-related address and a standard address
// - selector on safety position: address assignment writes the safety address
// - safety profile read gives id F, io 7, tens and units digits
// - selector on run position: address assignment writes the standard address
// - safe output mirrors the monitor second release circuit state
// - whole shutdown chain finishes within 70 ms worst case
// - parameter bit 1 at 0 enables functional switching, 1 disables, default disabled
// - functional enable output bit also gates the circuit when active
// - disrupted reception switches output off until a help signal
// - fault of 140 ms or more accepts only help signal 1
// - fault shorter than 140 ms requires help signal 2
// - three standard inputs and two independent standard outputs
// - normal communication: bus led steady green, fault led dark
// - no data exchange: fault led steady red
// - overload: fault led flashes red, bus led green
// - standard address 0: bus led flashes green, fault led red
// - output overload turns off all standard outputs
// - waiting for help signal reports 1 on fourth input bit
package safe_out_pkg;
    // ========================================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS         = 1000000;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int RESPONSE_MS   = 70;
    localparam logic [7:0] LONG_FAULT_MS = 8'h8c;
    localparam logic [7:0] FAULT_TOL_MS  = 8'h14;
    localparam logic [7:0] STD_LOSS_MS   = 8'h32;
    localparam logic [7:0] FLASH_MS      = 8'hfa;
    localparam logic [7:0] MS_MAX        = 8'hff;

    // ========================================================
    // widths and fields
    localparam int ADDR_W    = 5;
    localparam int NIB_W     = 4;
    localparam int PARAM_FUNC_BIT = 1;
    localparam int CMD_OUT_A = 0;
    localparam int CMD_OUT_B = 1;
    localparam int CMD_FUNC  = 2;
    localparam int ACK_BIT   = 3;
    localparam int PIN_W     = 6;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
    localparam logic [ADDR_W-1:0] DEC_BASE   = 5'h0a;

    // ========================================================
    // profiles; standard profile values are arbitrary
    localparam logic [NIB_W-1:0] SAFE_ID  = 4'hf;
    localparam logic [NIB_W-1:0] SAFE_IO  = 4'h7;
    localparam logic [NIB_W-1:0] STD_ID   = 4'ha;
    localparam logic [NIB_W-1:0] STD_IO   = 4'h7;
    localparam logic [NIB_W-1:0] STD_ID1  = 4'h7;
    localparam logic [NIB_W-1:0] STD_ID2  = 4'he;

    typedef enum logic [1:0] {SAFE_INIT, SAFE_RUN, SAFE_WAIT} safe_state_t;
endpackage : safe_out_pkg

// File: safe_output_slave_control.sv
// control of the two-address safe output slave
// assumes a bus front end on clk_i delivering decoded events, pins raw
`timescale 1ns/1ns
module safe_output_slave_control
    import safe_out_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              resetn_i,
    // front pins
    input  wire logic                              sel_safe_pin_i,
    input  wire logic [2:0]                        std_in_pin_i,
    input  wire logic                              sensor_ovl_pin_i,
    input  wire logic                              output_ovl_pin_i,
    // address assignment and profile read
    input  wire logic                              addr_assign_i,
    input  wire logic [safe_out_pkg::ADDR_W-1:0]   addr_value_i,
    input  wire logic                              profile_read_i,
    output logic                                   profile_valid_o,
    output logic      [safe_out_pkg::NIB_W-1:0]    profile_id_o,
    output logic      [safe_out_pkg::NIB_W-1:0]    profile_io_o,
    output logic      [safe_out_pkg::NIB_W-1:0]    profile_id1_o,
    output logic      [safe_out_pkg::NIB_W-1:0]    profile_id2_o,
    output logic      [safe_out_pkg::ADDR_W-1:0]   safe_addr_o,
    output logic      [safe_out_pkg::ADDR_W-1:0]   std_addr_o,
    // monitor code sequence, decoded
    input  wire logic                              seq_valid_i,
    input  wire logic [safe_out_pkg::ADDR_W-1:0]   seq_addr_i,
    input  wire logic                              seq_error_i,
    input  wire logic                              seq_enable_i,
    input  wire logic                              seq_help1_i,
    input  wire logic                              seq_help2_i,
    // standard slave exchange
    input  wire logic                              std_exchange_i,
    input  wire logic [safe_out_pkg::NIB_W-1:0]    std_cmd_i,
    input  wire logic                              param_write_i,
    input  wire logic [safe_out_pkg::NIB_W-1:0]    param_i,
    output logic      [safe_out_pkg::NIB_W-1:0]    std_in_o,
    output logic      [1:0]                        std_out_o,
    output logic                                   io_error_o,
    // safe output and leds
    output logic                                   safe_out_o,
    output logic                                   bus_led_o,
    output logic                                   fault_led_o
);
    import safe_out_pkg::*;

    typedef struct packed {
        safe_state_t       state;
        logic [ADDR_W-1:0] safe_addr;
        logic [ADDR_W-1:0] std_addr;
        logic              func_dis;
        logic [2:0]        std_cmd;
        logic              en_rx;
        logic [7:0]        gap_ms;
        logic [7:0]        fault_ms;
        logic [7:0]        std_gap_ms;
        logic              fault_on;
        logic              safe_out;
        logic [1:0]        std_out;
        logic [NIB_W-1:0]  std_in;
        logic              io_err;
        logic              bus_led;
        logic              fault_led;
        logic              prof_valid;
        logic [NIB_W-1:0]  prof_id;
        logic [NIB_W-1:0]  prof_io;
        logic [NIB_W-1:0]  prof_id1;
        logic [NIB_W-1:0]  prof_id2;
    } ctl_st_t;

    ctl_st_t st;
    ctl_st_t next_st;

    logic [PIN_W-1:0] pins;
    logic             ms_tick;
    logic             flash;
    logic             sel_safe;
    logic             ovl_sensor;
    logic             ovl_output;
    logic             good;
    logic             bad;
    logic             long_fault;
    logic             ack_ok;
    logic             comm_ok;

    // ========================================================
    // pins and tick
    pin_sync #(.W(PIN_W)) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .pin_i    ({output_ovl_pin_i, sensor_ovl_pin_i,
                    std_in_pin_i, sel_safe_pin_i}),
        .level_o  (pins)
    );

    tick_gen #(.MS_CYCLES(MS_CYCLES)) u_tick (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .ms_tick_o (ms_tick),
        .flash_o   (flash)
    );

    assign sel_safe   = pins[0];
    assign ovl_sensor = pins[4];
    assign ovl_output = pins[5];

    // ========================================================
    // reception qualifiers
    assign good = seq_valid_i && (seq_addr_i == st.safe_addr)
                  && !seq_error_i;
    assign bad  = (seq_valid_i && (seq_addr_i == st.safe_addr)
                   && seq_error_i)
                  || (st.gap_ms >= FAULT_TOL_MS);
    assign long_fault = (st.fault_ms >= LONG_FAULT_MS);
    assign ack_ok = long_fault ? seq_help1_i
                               : seq_help2_i;
    assign comm_ok = (st.std_gap_ms < STD_LOSS_MS);

    // ========================================================
    // next state
    always_comb begin
        logic [ADDR_W-1:0] units;
        logic [NIB_W-1:0]  tens;
        units = st.safe_addr;
        tens  = '0;
        next_st = st;
        next_st.prof_valid = 1'b0;

        // address assignment
        if (addr_assign_i) begin
            if (sel_safe) begin
                next_st.safe_addr = addr_value_i;
            end else begin
                next_st.std_addr = addr_value_i;
            end
        end

        // profile read
        for (int k = 0; k < 3; k++) begin
            if (units >= DEC_BASE) begin
                units = units - DEC_BASE;
                tens  = tens + 4'h1;
            end
        end
        if (profile_read_i) begin
            next_st.prof_valid = 1'b1;
            if (sel_safe) begin
                next_st.prof_id  = SAFE_ID;
                next_st.prof_io  = SAFE_IO;
                next_st.prof_id1 = tens;
                next_st.prof_id2 = NIB_W'(units);
            end else begin
                next_st.prof_id  = STD_ID;
                next_st.prof_io  = STD_IO;
                next_st.prof_id1 = STD_ID1;
                next_st.prof_id2 = STD_ID2;
            end
        end

        // standard slave
        if (param_write_i) begin
            next_st.func_dis = param_i[PARAM_FUNC_BIT];
        end
        if (std_exchange_i) begin
            next_st.std_cmd    = std_cmd_i[2:0];
            next_st.std_gap_ms = '0;
        end else if (ms_tick && st.std_gap_ms != MS_MAX) begin
            next_st.std_gap_ms = st.std_gap_ms + 8'h01;
        end
        next_st.std_out = ovl_output ? 2'b00
                        : {st.std_cmd[CMD_OUT_B], st.std_cmd[CMD_OUT_A]};
        next_st.std_in[2:0] = ovl_sensor ? 3'b000 : pins[3:1];
        next_st.std_in[ACK_BIT] = (st.state == SAFE_WAIT);
        next_st.io_err = ovl_sensor || ovl_output;

        // reception gap in ms
        if (good) begin
            next_st.gap_ms = '0;
            next_st.en_rx  = seq_enable_i;
        end else if (ms_tick && st.gap_ms != MS_MAX) begin
            next_st.gap_ms = st.gap_ms + 8'h01;
        end

        // safe state machine
        case (st.state)
            SAFE_INIT: begin
                if (good && seq_enable_i) begin
                    next_st.state = SAFE_RUN;
                end
            end
            SAFE_RUN: begin
                if (bad) begin
                    next_st.state    = SAFE_WAIT;
                    next_st.fault_on = 1'b1;
                    next_st.fault_ms = st.gap_ms;
                    next_st.en_rx    = 1'b0;
                end
            end
            SAFE_WAIT: begin
                if (bad) begin
                    next_st.fault_on = 1'b1;
                end else if (good) begin
                    next_st.fault_on = 1'b0;
                end
                if (st.fault_on && ms_tick && st.fault_ms != MS_MAX) begin
                    next_st.fault_ms = st.fault_ms + 8'h01;
                end
                if (good && ack_ok) begin
                    next_st.state    = SAFE_RUN;
                    next_st.fault_on = 1'b0;
                end
            end
            default: begin
                next_st.state = SAFE_INIT;
            end
        endcase

        // safe output, one cycle after its cause
        next_st.safe_out = (st.state == SAFE_RUN) && !bad && st.en_rx
                           && (st.func_dis || st.std_cmd[CMD_FUNC]);

        // leds
        if (st.std_addr == ADDR_RESET) begin
            next_st.bus_led   = flash;
            next_st.fault_led = 1'b1;
        end else if (!comm_ok) begin
            next_st.bus_led   = 1'b1;
            next_st.fault_led = 1'b1;
        end else if (ovl_sensor || ovl_output) begin
            next_st.bus_led   = 1'b1;
            next_st.fault_led = flash;
        end else begin
            next_st.bus_led   = 1'b1;
            next_st.fault_led = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st          <= '0;
            st.state    <= SAFE_INIT;
            st.func_dis <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================
    // outputs
    assign profile_valid_o = st.prof_valid;
    assign profile_id_o    = st.prof_id;
    assign profile_io_o    = st.prof_io;
    assign profile_id1_o   = st.prof_id1;
    assign profile_id2_o   = st.prof_id2;
    assign safe_addr_o     = st.safe_addr;
    assign std_addr_o      = st.std_addr;
    assign std_in_o        = st.std_in;
    assign std_out_o       = st.std_out;
    assign io_error_o      = st.io_err;
    assign safe_out_o      = st.safe_out;
    assign bus_led_o       = st.bus_led;
    assign fault_led_o     = st.fault_led;

    // ========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_fault_entry;
        st.state == SAFE_RUN ##1 st.state == SAFE_WAIT;
    endsequence

    sequence s_wait_pending;
        st.state == SAFE_WAIT && !(good && seq_help1_i);
    endsequence

    a_fault_off: assert property (s_fault_entry |-> ##1 !safe_out_o)
        else $error("safe output on after fault entry");
    a_not_run_off: assert property (st.state != SAFE_RUN |=> !safe_out_o)
        else $error("safe output on outside run");
    a_mirror_on: assert property (st.state == SAFE_RUN && !bad && st.en_rx
        && st.func_dis |=> safe_out_o)
        else $error("safe output not mirroring release circuit");
    a_func_gate: assert property (!st.func_dis && !st.std_cmd[CMD_FUNC]
        |=> !safe_out_o)
        else $error("functional switching not gating output");
    a_long_help: assert property (s_wait_pending ##0 long_fault
        |=> st.state == SAFE_WAIT)
        else $error("long fault left without help one");
    a_short_help: assert property (st.state == SAFE_WAIT && !long_fault
        && good && seq_help1_i && !seq_help2_i |=> st.state == SAFE_WAIT)
        else $error("short fault left without help two");
    a_ack_flag: assert property (st.state == SAFE_WAIT
        |=> std_in_o[ACK_BIT])
        else $error("ack request bit not set while waiting");
    a_ovl_outs: assert property (ovl_output |=> std_out_o == 2'b00)
        else $error("standard outputs on during overload");
    a_safe_prof: assert property (profile_read_i && sel_safe |=>
        profile_valid_o && profile_id_o == SAFE_ID
        && profile_io_o == SAFE_IO)
        else $error("wrong safety profile");
    a_addr_safe: assert property (addr_assign_i && sel_safe |=>
        safe_addr_o == $past(addr_value_i) && $stable(std_addr_o))
        else $error("safety address not assigned");
    a_addr_std: assert property (addr_assign_i && !sel_safe |=>
        std_addr_o == $past(addr_value_i))
        else $error("standard address not assigned");
    a_led_zero: assert property (st.std_addr == ADDR_RESET
        |=> fault_led_o)
        else $error("fault led dark at address zero");
endmodule : safe_output_slave_control

// File: tb_top.sv
// self-checking bench of the safe output slave control
// assumes the monitor model is compiled before this file
`timescale 1ns/1ns
module tb_top;
    import safe_out_pkg::*;
    // ========================================================
    // signals
    logic        clk_i = 1'b0;
    logic        resetn_i, sel_safe_pin_i, sensor_ovl_pin_i;
    logic        output_ovl_pin_i, addr_assign_i, profile_read_i;
    logic        seq_valid_i, seq_error_i, seq_enable_i, seq_help1_i;
    logic        seq_help2_i, std_exchange_i = 1'b0, param_write_i;
    logic        profile_valid_o, io_error_o, safe_out_o;
    logic        bus_led_o, fault_led_o, exch_on;
    logic        mon_send, mon_en, mon_h1, mon_h2, mon_err;
    logic [1:0]  std_out_o;
    logic [2:0]  std_in_pin_i;
    logic [3:0]  std_cmd_i, param_i, std_in_o, profile_id_o;
    logic [3:0]  profile_io_o, profile_id1_o, profile_id2_o;
    logic [4:0]  addr_value_i, seq_addr_i, safe_addr_o, std_addr_o;
    logic [4:0]  mon_addr, sa, sd;
    logic [15:0] exp_q[$];
    int          n_errors = 0, samples_checked = 0, xcnt = 0, bc, fc;

    // ========================================================
    // design and monitor model
    safe_output_slave_control #(.MS_CYCLES(10)) u_safe_output_slave_control (
        .clk_i(clk_i), .resetn_i(resetn_i), .sel_safe_pin_i(sel_safe_pin_i),
        .std_in_pin_i(std_in_pin_i), .sensor_ovl_pin_i(sensor_ovl_pin_i),
        .output_ovl_pin_i(output_ovl_pin_i), .addr_assign_i(addr_assign_i),
        .addr_value_i(addr_value_i), .profile_read_i(profile_read_i),
        .profile_valid_o(profile_valid_o), .profile_id_o(profile_id_o),
        .profile_io_o(profile_io_o), .profile_id1_o(profile_id1_o),
        .profile_id2_o(profile_id2_o), .safe_addr_o(safe_addr_o),
        .std_addr_o(std_addr_o), .seq_valid_i(seq_valid_i),
        .seq_addr_i(seq_addr_i), .seq_error_i(seq_error_i),
        .seq_enable_i(seq_enable_i), .seq_help1_i(seq_help1_i),
        .seq_help2_i(seq_help2_i), .std_exchange_i(std_exchange_i),
        .std_cmd_i(std_cmd_i), .param_write_i(param_write_i),
        .param_i(param_i), .std_in_o(std_in_o), .std_out_o(std_out_o),
        .io_error_o(io_error_o), .safe_out_o(safe_out_o),
        .bus_led_o(bus_led_o), .fault_led_o(fault_led_o));
    safe_monitor_model u_safe_monitor_model (
        .clk_i(clk_i), .resetn_i(resetn_i), .send_i(mon_send),
        .addr_i(mon_addr), .enable_i(mon_en), .help1_i(mon_h1),
        .help2_i(mon_h2), .error_i(mon_err), .seq_valid_o(seq_valid_i),
        .seq_addr_o(seq_addr_i), .seq_enable_o(seq_enable_i),
        .seq_help1_o(seq_help1_i), .seq_help2_o(seq_help2_i),
        .seq_error_o(seq_error_i));

    // ========================================================
    // clock, helpers
    always #50 clk_i = ~clk_i;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask : pulse

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic led_watch(input int n);
        logic b, f;
        bc = 0;
        fc = 0;
        repeat (n) begin
            b = bus_led_o;
            f = fault_led_o;
            cyc(1);
            bc += (bus_led_o !== b);
            fc += (fault_led_o !== f);
        end
    endtask : led_watch

    task automatic complete_run;
        if (n_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    // ========================================================
    // background exchange and profile checker
    always @(posedge clk_i) begin
        #1;
        xcnt++;
        std_exchange_i = exch_on && (xcnt % 20 == 0);
    end

    always @(negedge clk_i)
        if (profile_valid_o === 1'b1) begin
            if (exp_q.size() == 0)
                check(1, 0);
            else
                check({profile_id_o, profile_io_o, profile_id1_o,
                       profile_id2_o}, exp_q.pop_front());
        end

    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        complete_run();
    end

    // ========================================================
    // main sequence
    initial begin
        {resetn_i, sel_safe_pin_i, sensor_ovl_pin_i, output_ovl_pin_i} = 0;
        {addr_assign_i, profile_read_i, param_write_i} = 0;
        {exch_on, mon_send, mon_en, mon_h1, mon_h2, mon_err} = 0;
        {std_in_pin_i, std_cmd_i, param_i, addr_value_i, mon_addr} = 0;
        void'($urandom(58533));
        repeat (20) @(posedge clk_i);
        check(safe_out_o, 0);
        #1 resetn_i = 1'b1;
        cyc(3);
        led_watch(5100);
        check(bc > 0, 1);
        check({fc == 0, fault_led_o}, 3);
        sel_safe_pin_i = 1'b1;
        cyc(4);
        sa = 5'($urandom_range(31, 1));
        addr_value_i = sa;
        pulse(addr_assign_i);
        check({safe_addr_o, std_addr_o}, {sa, 5'h00});
        exp_q.push_back({4'hf, 4'h7, 4'(sa / 10), 4'(sa % 10)});
        pulse(profile_read_i);
        sel_safe_pin_i = 1'b0;
        cyc(4);
        exp_q.push_back({STD_ID, STD_IO, STD_ID1, STD_ID2});
        pulse(profile_read_i);
        sd = 5'($urandom_range(31, 1));
        addr_value_i = sd;
        pulse(addr_assign_i);
        check({safe_addr_o, std_addr_o}, {sa, sd});
        exch_on = 1'b1;
        std_cmd_i = {2'b00, 2'($urandom)};
        std_in_pin_i = 3'($urandom);
        {mon_addr, mon_en, mon_send} = {sa ^ 5'h01, 2'b11};
        cyc(100);
        check(safe_out_o, 0);
        mon_addr = sa;
        cyc(100);
        check(safe_out_o, 1);
        check({std_out_o, std_in_o}, {std_cmd_i[1:0], 1'b0, std_in_pin_i});
        led_watch(300);
        check({bc == 0, fc == 0, bus_led_o, fault_led_o}, 14);
        mon_en = 1'b0;
        cyc(60);
        check(safe_out_o, 0);
        mon_en = 1'b1;
        cyc(60);
        check(safe_out_o, 1);
        param_i = 4'h0;
        pulse(param_write_i);
        cyc(60);
        check(safe_out_o, 0);
        std_cmd_i[2] = 1'b1;
        cyc(60);
        check(safe_out_o, 1);
        param_i = 4'h2;
        pulse(param_write_i);
        std_cmd_i[2] = 1'b0;
        cyc(60);
        check(safe_out_o, 1);
        mon_send = 1'b0;
        cyc(250);
        check({safe_out_o, std_in_o[3]}, 1);
        cyc(250);
        mon_send = 1'b1;
        cyc(200);
        check({safe_out_o, std_in_o[3]}, 1);
        mon_h1 = 1'b1;
        cyc(100);
        check(safe_out_o, 0);
        {mon_h1, mon_h2} = 2'b01;
        cyc(100);
        check({safe_out_o, std_in_o[3]}, 2);
        mon_err = 1'b1;
        cyc(50);
        check(safe_out_o, 0);
        mon_err = 1'b0;
        cyc(100);
        check(safe_out_o, 1);
        mon_send = 1'b0;
        cyc(1700);
        mon_send = 1'b1;
        cyc(200);
        check(safe_out_o, 0);
        {mon_h1, mon_h2} = 2'b10;
        cyc(100);
        check(safe_out_o, 1);
        mon_h1 = 1'b0;
        exch_on = 1'b0;
        cyc(600);
        check({bus_led_o, fault_led_o, safe_out_o}, 7);
        exch_on = 1'b1;
        std_cmd_i = 4'h3;
        cyc(50);
        check({fault_led_o, std_out_o}, 3);
        output_ovl_pin_i = 1'b1;
        cyc(5);
        check({std_out_o, io_error_o}, 1);
        led_watch(5100);
        check({bc == 0, fc > 0, bus_led_o, safe_out_o}, 15);
        {output_ovl_pin_i, sensor_ovl_pin_i, std_in_pin_i} = 5'h0f;
        cyc(30);
        check({std_in_o[2:0], io_error_o}, 1);
        check(exp_q.size(), 0);
        complete_run();
    end
endmodule : tb_top

// File: tick_gen.sv
// millisecond tick and led flash toggle
// assumes one clock; ms_cycles sets the divider
`timescale 1ns/1ns
module tick_gen
    import safe_out_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // enables
    output logic      ms_tick_o,
    output logic      flash_o
);
    typedef struct packed {
        logic [15:0] div;
        logic [7:0]  fms;
        logic        tick;
        logic        flash;
    } tick_st_t;

    tick_st_t st;
    tick_st_t next_st;

    // ========================================================
    // divider
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.div == 16'(MS_CYCLES - 1)) begin
            next_st.div  = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 16'h0001;
        end
        if (st.tick) begin
            if (st.fms == FLASH_MS - 8'h01) begin
                next_st.fms   = '0;
                next_st.flash = ~st.flash;
            end else begin
                next_st.fms = st.fms + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ms_tick_o = st.tick;
    assign flash_o   = st.flash;
endmodule : tick_gen
